/* design/cb_cfg_pkg.sv */
// constants for the card bridge configuration header slice
// assumes 32-bit configuration dwords addressed by byte offset bits 7..2
package cb_cfg_pkg;

  // number of socket functions, each with its own header copy
  localparam int FUNC_COUNT = 2;

  // byte offsets of the registers in the configuration header
  localparam logic [7:0] OFS_SELF_TEST = 8'h0F;
  localparam logic [7:0] OFS_SOCKET_BASE = 8'h10;
  localparam logic [7:0] OFS_CAP_POINTER = 8'h14;
  localparam logic [7:0] OFS_CARD_STATUS = 8'h16;
  localparam logic [7:0] OFS_PM_CAP = 8'hA0;
  localparam logic [7:0] OFS_PM_CTRL = 8'hA4;

  // bit position of each byte or half-dword register inside its dword
  localparam int SELF_TEST_LSB = 24;
  localparam int CAP_POINTER_LSB = 0;
  localparam int CARD_STATUS_LSB = 16;

  // values after reset and fixed read values
  localparam logic [7:0] SELF_TEST_RST = 8'h00;
  localparam logic [19:0] SOCKET_BASE_RST = 20'h00000;
  localparam logic [7:0] CAP_POINTER_VALUE = 8'hA0;
  localparam logic [15:0] CARD_STATUS_RST = 16'h0200;
  localparam logic [1:0] PM_STATE_RST = 2'h0;

  // socket window: base holds address bits 31..12, legacy set from 800h
  localparam int SOCKET_BASE_LSB = 12;
  localparam logic [11:0] LEGACY_REGS_OFS = 12'h800;

  // card side status fields
  localparam int CARD_PARITY_BIT = 15;
  localparam int CARD_SERR_BIT = 14;
  localparam int CARD_MABORT_BIT = 13;
  localparam int CARD_TA_REC_BIT = 12;
  localparam int CARD_TA_SIG_BIT = 11;
  localparam int CARD_DPAR_BIT = 8;
  localparam int CARD_SELECT_TIMING_LSB = 9;
  localparam logic [1:0] CARD_SELECT_TIMING = 2'h1;

  // sticky flag slots inside the flag keeper
  localparam int FLAG_COUNT = 6;
  localparam int FL_PARITY = 0;
  localparam int FL_SERR = 1;
  localparam int FL_MABORT = 2;
  localparam int FL_TA_REC = 3;
  localparam int FL_TA_SIG = 4;
  localparam int FL_DPAR = 5;

  // synchronised card pins: two error strobes per socket
  localparam int PIN_COUNT = 4;

endpackage : cb_cfg_pkg

/* design/card_flag_if.sv */
// carries sticky flag set and clear strobes between top and flag keeper
// assumes both ends on core_clk_in
`timescale 1ns/100ps
interface card_flag_if;
  import cb_cfg_pkg::*;
  logic [FLAG_COUNT-1:0] set;
  logic [FLAG_COUNT-1:0] clear;
  logic [FLAG_COUNT-1:0] flag;
  modport keeper(input set, input clear, output flag);
  modport user(output set, output clear, input flag);
endinterface : card_flag_if

/* design/card_status_flags.sv */
// sticky card side status flags of one socket function
// assumes set and clear strobes are synchronous to core_clk_in
`timescale 1ns/100ps
module card_status_flags
  import cb_cfg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  card_flag_if.keeper flags
);

  typedef struct packed {
    logic [FLAG_COUNT-1:0] flag_ff;
  } flag_state_t;

  flag_state_t st_ff;
  flag_state_t nxt_st;
  logic [FLAG_COUNT-1:0] nxt_bits;

  // per flag: a set in the clearing cycle wins over the clear
  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
    assign nxt_bits[i] = flags.set[i] | (st_ff.flag_ff[i] & ~flags.clear[i]);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.flag_ff = nxt_bits;
  end

  // synchronous reset drops every flag
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flags.flag = st_ff.flag_ff;

endmodule : card_status_flags

/* design/card_pin_sync.sv */
// two flop synchroniser for the card error pins
// assumes the pins are asynchronous to core_clk_in; they idle high
`timescale 1ns/100ps
module card_pin_sync
  import cb_cfg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] stage1_ff;
    logic [PIN_COUNT-1:0] stage2_ff;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  // first stage feeds only the second
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage1_ff = pin_in;
    nxt_st.stage2_ff = st_ff.stage1_ff;
  end

  // reset to the idle (released) pin level
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.stage2_ff;

endmodule : card_pin_sync

/* design/cardbus_bridge_config_regs.sv */
// configuration header slice of a two socket card bridge:
// self test, socket window base, capability pointer, card side status
// assumes configuration cycles arrive as one-cycle strobes on core_clk_in,
// card event strobes come from logic on core_clk_in, error pins are async
//
// Operation
// - self test ignores writes, reads zero
// - base bits 31..12 store host writes
// - base bits 11..0 always read zero
// - all ones write reads back FFFFF000h
// - window: socket regs 000h, legacy 800h
// - each socket function owns its base
// - capability pointer constant A0h, read only
// - power management dwords at A0h, A4h
// - writing one clears a status flag
// - card parity error sets bit 15
// - card system error sets bit 14, never driven
// - own cycle master abort sets bit 13
// - target abort received sets bit 12
// - target abort signalled sets bit 11
// - select timing bits fixed medium 01b
// - bit 8 needs error, mastership, enable
// - bits 7..0 read as zero
`timescale 1ns/100ps
module cardbus_bridge_config_regs
  import cb_cfg_pkg::*;
#(
  // power management capability dword; value is arbitrary
  parameter logic [31:0] PM_CAP_WORD = 32'h00000001
)
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // configuration access port
  input wire logic cfg_rd_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_func_in,
  input wire logic [5:0] cfg_dword_in,
  input wire logic [3:0] cfg_byte_en_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  // memory cycles to be checked against the socket windows
  input wire logic mem_valid_in,
  input wire logic [31:0] mem_addr_in,
  output logic [FUNC_COUNT-1:0] socket_regs_hit_out,
  output logic [FUNC_COUNT-1:0] legacy_regs_hit_out,
  output logic [10:0] window_offset_out,
  // card side events, one bit per socket function
  input wire logic [FUNC_COUNT-1:0] card_parity_detected_in,
  input wire logic [FUNC_COUNT-1:0] card_master_abort_received_in,
  input wire logic [FUNC_COUNT-1:0] card_target_abort_received_in,
  input wire logic [FUNC_COUNT-1:0] card_target_abort_signaled_in,
  input wire logic [FUNC_COUNT-1:0] card_master_data_phase_in,
  input wire logic [FUNC_COUNT-1:0] parity_response_enable_in,
  // card error pins, active low, asynchronous
  input wire logic [FUNC_COUNT-1:0] card_system_error_n_in,
  input wire logic [FUNC_COUNT-1:0] card_parity_error_n_in,
  // system error pin enable, low would mean driving
  output logic [FUNC_COUNT-1:0] card_system_error_oe_n_out,
  // card side status of each function, for the rest of the bridge
  output logic [FUNC_COUNT-1:0][15:0] card_side_status_out
);

  localparam logic [5:0] DW_SELF_TEST = OFS_SELF_TEST[7:2];
  localparam logic [5:0] DW_SOCKET_BASE = OFS_SOCKET_BASE[7:2];
  localparam logic [5:0] DW_CAP_STATUS = OFS_CAP_POINTER[7:2];
  localparam logic [5:0] DW_PM_CAP = OFS_PM_CAP[7:2];
  localparam logic [5:0] DW_PM_CTRL = OFS_PM_CTRL[7:2];

  typedef struct packed {
    logic [FUNC_COUNT-1:0][19:0] socket_base_ff;
    logic [FUNC_COUNT-1:0][1:0] pm_state_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic [FUNC_COUNT-1:0] socket_hit_ff;
    logic [FUNC_COUNT-1:0] legacy_hit_ff;
    logic [10:0] window_offset_ff;
    logic [FUNC_COUNT-1:0] serr_oe_n_ff;
    logic [FUNC_COUNT-1:0][15:0] status_ff;
  } cfg_state_t;

  cfg_state_t st_ff;
  cfg_state_t nxt_st;

  // synchronised error pins, low means asserted
  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_sync;
  logic [FUNC_COUNT-1:0] serr_seen;
  logic [FUNC_COUNT-1:0] perr_seen;

  // sticky flags of each function, and the assembled status words
  logic [FUNC_COUNT-1:0][FLAG_COUNT-1:0] flag_bits;
  logic [FUNC_COUNT-1:0][15:0] status_word;

  // write strobe that reaches the status high byte of one function
  logic [FUNC_COUNT-1:0] status_clear_hit;

  assign pins_raw = {card_parity_error_n_in, card_system_error_n_in};

  // pins come from the card, so they settle through two flops first
  card_pin_sync u_pin_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  assign serr_seen = ~pins_sync[FUNC_COUNT-1:0];
  assign perr_seen = ~pins_sync[PIN_COUNT-1:FUNC_COUNT];

  // one flag keeper per socket function
  for (genvar f = 0; f < FUNC_COUNT; f++) begin : g_func
    card_flag_if flag_link ();

    // status flags live only in the high byte, lane 3 of the dword
    assign status_clear_hit[f] = cfg_wr_in & (cfg_func_in == 1'(f)) & (cfg_dword_in == DW_CAP_STATUS)
                                 & cfg_byte_en_in[3];

    // event sources, each a level or strobe on core_clk_in
    assign flag_link.set[FL_PARITY] = card_parity_detected_in[f];
    assign flag_link.set[FL_SERR] = serr_seen[f];
    assign flag_link.set[FL_MABORT] = card_master_abort_received_in[f];
    assign flag_link.set[FL_TA_REC] = card_target_abort_received_in[f];
    assign flag_link.set[FL_TA_SIG] = card_target_abort_signaled_in[f];
    // all three must hold in the same cycle
    assign flag_link.set[FL_DPAR] = perr_seen[f] & card_master_data_phase_in[f]
                                    & parity_response_enable_in[f];

    // write data bits line up with status bits 15..8 shifted by 16
    assign flag_link.clear[FL_PARITY] = status_clear_hit[f]
                                        & cfg_wdata_in[CARD_STATUS_LSB + CARD_PARITY_BIT];
    assign flag_link.clear[FL_SERR] = status_clear_hit[f]
                                      & cfg_wdata_in[CARD_STATUS_LSB + CARD_SERR_BIT];
    assign flag_link.clear[FL_MABORT] = status_clear_hit[f]
                                        & cfg_wdata_in[CARD_STATUS_LSB + CARD_MABORT_BIT];
    assign flag_link.clear[FL_TA_REC] = status_clear_hit[f]
                                        & cfg_wdata_in[CARD_STATUS_LSB + CARD_TA_REC_BIT];
    assign flag_link.clear[FL_TA_SIG] = status_clear_hit[f]
                                        & cfg_wdata_in[CARD_STATUS_LSB + CARD_TA_SIG_BIT];
    assign flag_link.clear[FL_DPAR] = status_clear_hit[f]
                                      & cfg_wdata_in[CARD_STATUS_LSB + CARD_DPAR_BIT];

    card_status_flags u_flags (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .flags(flag_link)
    );

    assign flag_bits[f] = flag_link.flag;
  end

  // status word: flags in place, timing fixed, everything else zero
  always_comb begin
    for (int f = 0; f < FUNC_COUNT; f++) begin
      status_word[f] = 16'h0000;
      status_word[f][CARD_PARITY_BIT] = flag_bits[f][FL_PARITY];
      status_word[f][CARD_SERR_BIT] = flag_bits[f][FL_SERR];
      status_word[f][CARD_MABORT_BIT] = flag_bits[f][FL_MABORT];
      status_word[f][CARD_TA_REC_BIT] = flag_bits[f][FL_TA_REC];
      status_word[f][CARD_TA_SIG_BIT] = flag_bits[f][FL_TA_SIG];
      status_word[f][CARD_DPAR_BIT] = flag_bits[f][FL_DPAR];
      status_word[f][CARD_SELECT_TIMING_LSB +: 2] = CARD_SELECT_TIMING;
    end
  end

  // next state: configuration writes, read capture, window decode
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack_ff = cfg_rd_in | cfg_wr_in;
    nxt_st.status_ff = status_word;
    // the bridge never drives the card system error line
    nxt_st.serr_oe_n_ff = '1;

    // writes: only base bits 31..12 and the power state take data
    if (cfg_wr_in) begin
      for (int f = 0; f < FUNC_COUNT; f++) begin
        if (cfg_func_in == f[0]) begin
          if (cfg_dword_in == DW_SOCKET_BASE) begin
            // lane 1 holds base bits 15..12 only; 11..8 are not stored
            if (cfg_byte_en_in[1]) begin
              nxt_st.socket_base_ff[f][3:0] = cfg_wdata_in[15:12];
            end
            if (cfg_byte_en_in[2]) begin
              nxt_st.socket_base_ff[f][11:4] = cfg_wdata_in[23:16];
            end
            if (cfg_byte_en_in[3]) begin
              nxt_st.socket_base_ff[f][19:12] = cfg_wdata_in[31:24];
            end
          end
          if ((cfg_dword_in == DW_PM_CTRL) && cfg_byte_en_in[0]) begin
            nxt_st.pm_state_ff[f] = cfg_wdata_in[1:0];
          end
        end
      end
      // self test and capability pointer have no storage to write
    end

    // reads: answer captured for the cycle after the strobe
    if (cfg_rd_in) begin
      nxt_st.rdata_ff = 32'h00000000;
      case (cfg_dword_in)
        DW_SELF_TEST: begin
          nxt_st.rdata_ff[SELF_TEST_LSB +: 8] = SELF_TEST_RST;
        end
        DW_SOCKET_BASE: begin
          // low twelve bits stay zero, so all ones reads FFFFF000h
          nxt_st.rdata_ff = {st_ff.socket_base_ff[cfg_func_in], 12'h000};
        end
        DW_CAP_STATUS: begin
          nxt_st.rdata_ff[CAP_POINTER_LSB +: 8] = CAP_POINTER_VALUE;
          nxt_st.rdata_ff[CARD_STATUS_LSB +: 16] = status_word[cfg_func_in];
        end
        DW_PM_CAP: begin
          nxt_st.rdata_ff = PM_CAP_WORD;
        end
        DW_PM_CTRL: begin
          nxt_st.rdata_ff[1:0] = st_ff.pm_state_ff[cfg_func_in];
        end
        default: begin
          // dwords outside this slice read as zero
          nxt_st.rdata_ff = 32'h00000000;
        end
      endcase
    end

    // window decode; a zero base leaves the window closed
    nxt_st.socket_hit_ff = '0;
    nxt_st.legacy_hit_ff = '0;
    nxt_st.window_offset_ff = mem_addr_in[10:0];
    if (mem_valid_in) begin
      for (int f = 0; f < FUNC_COUNT; f++) begin
        if ((st_ff.socket_base_ff[f] != SOCKET_BASE_RST)
            && (mem_addr_in[31:SOCKET_BASE_LSB] == st_ff.socket_base_ff[f])) begin
          // bit 11 splits the 4K window at 800h
          if (mem_addr_in[11:0] >= LEGACY_REGS_OFS) begin
            nxt_st.legacy_hit_ff[f] = 1'b1;
          end else begin
            nxt_st.socket_hit_ff[f] = 1'b1;
          end
        end
      end
    end
  end

  // one register stage for all state; synchronous reset
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_ff.socket_base_ff <= {FUNC_COUNT{SOCKET_BASE_RST}};
      st_ff.pm_state_ff <= {FUNC_COUNT{PM_STATE_RST}};
      st_ff.rdata_ff <= 32'h00000000;
      st_ff.ack_ff <= 1'b0;
      st_ff.socket_hit_ff <= '0;
      st_ff.legacy_hit_ff <= '0;
      st_ff.window_offset_ff <= 11'h000;
      st_ff.serr_oe_n_ff <= '1;
      st_ff.status_ff <= {FUNC_COUNT{CARD_STATUS_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign cfg_rdata_out = st_ff.rdata_ff;
  assign cfg_ack_out = st_ff.ack_ff;
  assign socket_regs_hit_out = st_ff.socket_hit_ff;
  assign legacy_regs_hit_out = st_ff.legacy_hit_ff;
  assign window_offset_out = st_ff.window_offset_ff;
  assign card_system_error_oe_n_out = st_ff.serr_oe_n_ff;
  assign card_side_status_out = st_ff.status_ff;

endmodule : cardbus_bridge_config_regs

/* verification/cb_cfg_properties.sv */
// timing checks on the ports of the card bridge configuration slice
// assumes bind to cardbus_bridge_config_regs, one clock, sync reset
`timescale 1ns/100ps
module cb_cfg_checker
  import cb_cfg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_func_in,
  input wire logic [5:0] cfg_dword_in,
  input wire logic [3:0] cfg_byte_en_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic mem_valid_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [FUNC_COUNT-1:0] socket_regs_hit_out,
  input wire logic [FUNC_COUNT-1:0] legacy_regs_hit_out,
  input wire logic [FUNC_COUNT-1:0] card_parity_detected_in,
  input wire logic [FUNC_COUNT-1:0] card_master_abort_received_in,
  input wire logic [FUNC_COUNT-1:0] card_system_error_oe_n_out,
  input wire logic [FUNC_COUNT-1:0][15:0] card_side_status_out
);
  logic clr_par0;
  // a write that clears the parity flag of function 0
  assign clr_par0 = cfg_wr_in && cfg_byte_en_in[3] && cfg_wdata_in[31] && !cfg_func_in && cfg_dword_in == 6'h05;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  self_test_zero_a: assert property (cfg_rd_in && cfg_dword_in == 6'h03 |=> cfg_rdata_out[31:24] == 8'h00)
    else $error("self test byte not zero");
  base_low_zero_a: assert property (cfg_rd_in && cfg_dword_in == 6'h04 |=> cfg_rdata_out[11:0] == 12'h000)
    else $error("base low bits not zero");
  cap_ptr_fixed_a: assert property (cfg_rd_in && cfg_dword_in == 6'h05 |=> cfg_rdata_out[7:0] == 8'hA0)
    else $error("capability pointer wrong");
  no_serr_drive_a: assert property (card_system_error_oe_n_out == 2'h3)
    else $error("system error pin driven");
  fixed_bits_a: assert property ({card_side_status_out[0][10:9], card_side_status_out[0][7:0],
    card_side_status_out[1][10:9], card_side_status_out[1][7:0]} == 20'h40100) else $error("fixed status bits wrong");
  parity_sets_a: assert property (card_parity_detected_in[0] |-> ##2 card_side_status_out[0][15])
    else $error("parity flag not set");
  mabort_sets_a: assert property (card_master_abort_received_in[1] |-> ##2 card_side_status_out[1][13])
    else $error("master abort flag not set");
  flag_sticks_a: assert property ($fell(card_side_status_out[0][15]) |-> $past(clr_par0, 2))
    else $error("parity flag dropped without clear");
  socket_kind_a: assert property (socket_regs_hit_out != 2'h0 |-> $past(mem_valid_in) && !$past(mem_addr_in[11]))
    else $error("socket hit outside lower half");
  legacy_kind_a: assert property (legacy_regs_hit_out != 2'h0 |-> $past(mem_valid_in) && $past(mem_addr_in[11]))
    else $error("legacy hit outside upper half");
endmodule : cb_cfg_checker

bind cardbus_bridge_config_regs cb_cfg_checker chk (.core_clk_in, .rstn_in, .cfg_rd_in, .cfg_wr_in, .cfg_func_in,
  .cfg_dword_in, .cfg_byte_en_in, .cfg_wdata_in, .cfg_rdata_out, .mem_valid_in, .mem_addr_in, .socket_regs_hit_out,
  .legacy_regs_hit_out, .card_parity_detected_in, .card_master_abort_received_in, .card_system_error_oe_n_out,
  .card_side_status_out);

/* verification/card_side_model.sv */
// card side of the bridge: event strobes and the two error pins
// assumes pins are pulled up and idle high, strobes start on falling edges
`timescale 1ns/100ps
module card_side_model
  import cb_cfg_pkg::*;
(
  input wire logic core_clk_in,
  output logic [FUNC_COUNT-1:0] parity_out,
  output logic [FUNC_COUNT-1:0] mabort_out,
  output logic [FUNC_COUNT-1:0] ta_rec_out,
  output logic [FUNC_COUNT-1:0] ta_sig_out,
  output logic [FUNC_COUNT-1:0] serr_n_out,
  output logic [FUNC_COUNT-1:0] perr_n_out
);
  logic [5:0][FUNC_COUNT-1:0] ev;
  // pins low only while pulsed, pull-up level otherwise
  assign {perr_n_out, serr_n_out} = ~ev[5:4];
  assign {ta_sig_out, ta_rec_out, mabort_out, parity_out} = ev[3:0];
  initial ev = '0;
  // one cycle event of kind k on socket f
  task automatic strobe(input int k, input int f);
    @(negedge core_clk_in);
    ev[k][f] = 1'b1;
    @(negedge core_clk_in);
    ev = '0;
  endtask : strobe
endmodule : card_side_model

/* verification/tb_top.sv */
// self-checking bench for the card bridge configuration slice
// assumes inputs change on falling edges, checks after the answer edge
`timescale 1ns/100ps
module tb_top;
  import cb_cfg_pkg::*;
  localparam logic [31:0] PM_WORD = 32'h00C30001; // arbitrary
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cfg_rd_in = 1'b0, cfg_wr_in = 1'b0, cfg_func_in = 1'b0, mem_valid_in = 1'b0, cfg_ack_out;
  logic [5:0] cfg_dword_in = 6'h00;
  logic [3:0] cfg_byte_en_in = 4'h0;
  logic [31:0] cfg_wdata_in = 32'h0, mem_addr_in = 32'h0, cfg_rdata_out;
  logic [1:0] card_master_data_phase_in = 2'h0, parity_response_enable_in = 2'h0;
  logic [1:0] par, mab, tar, tas, serr_n, perr_n, socket_regs_hit_out, legacy_regs_hit_out, card_system_error_oe_n_out;
  logic [10:0] window_offset_out;
  logic [1:0][15:0] card_side_status_out;
  int error_cnt = 0, num_checks = 0, cycles = 0;
  int pos [5] = '{15, 13, 12, 11, 14};
  always #2.5 core_clk_in = ~core_clk_in;
  cardbus_bridge_config_regs #(.PM_CAP_WORD(PM_WORD)) dut (.core_clk_in, .rstn_in, .cfg_rd_in, .cfg_wr_in,
    .cfg_func_in, .cfg_dword_in, .cfg_byte_en_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_ack_out, .mem_valid_in,
    .mem_addr_in, .socket_regs_hit_out, .legacy_regs_hit_out, .window_offset_out, .card_parity_detected_in(par),
    .card_master_abort_received_in(mab), .card_target_abort_received_in(tar), .card_target_abort_signaled_in(tas),
    .card_master_data_phase_in, .parity_response_enable_in, .card_system_error_n_in(serr_n),
    .card_parity_error_n_in(perr_n), .card_system_error_oe_n_out, .card_side_status_out);
  card_side_model card (.core_clk_in, .parity_out(par), .mabort_out(mab), .ta_rec_out(tar), .ta_sig_out(tas),
    .serr_n_out(serr_n), .perr_n_out(perr_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one config strobe; ack is due on the following edge
  task automatic cfg(input logic w, input logic f, input logic [5:0] d, input logic [3:0] be, input logic [31:0] v);
    @(negedge core_clk_in);
    cfg_rd_in = ~w;
    cfg_wr_in = w;
    cfg_func_in = f;
    cfg_dword_in = d;
    cfg_byte_en_in = be;
    cfg_wdata_in = v;
    @(negedge core_clk_in);
    cfg_rd_in = 1'b0;
    cfg_wr_in = 1'b0;
    chk(cfg_ack_out, 32'h1);
  endtask : cfg
  task automatic wr(input logic f, input logic [5:0] d, input logic [3:0] be, input logic [31:0] v);
    cfg(1'b1, f, d, be, v);
  endtask : wr
  // masked read compare
  task automatic rdc(input logic f, input logic [5:0] d, input logic [31:0] m, input logic [31:0] e);
    cfg(1'b0, f, d, 4'hF, 32'h0);
    chk(cfg_rdata_out & m, e);
  endtask : rdc
  // one memory cycle, hits and offset due one cycle later
  task automatic mem(input logic [31:0] a, input logic [1:0] s, input logic [1:0] l);
    @(negedge core_clk_in);
    mem_valid_in = 1'b1;
    mem_addr_in = a;
    @(negedge core_clk_in);
    mem_valid_in = 1'b0;
    chk({socket_regs_hit_out, legacy_regs_hit_out, window_offset_out}, {s, l, a[10:0]});
  endtask : mem
  task automatic do_reset();
    rstn_in = 1'b0;
    repeat (6) @(negedge core_clk_in);
    rstn_in = 1'b1;
  endtask : do_reset
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    do_reset();
    for (int f = 0; f < 2; f++) begin
      wr(f[0], 6'h03, 4'hF, 32'hFFFFFFFF);
      rdc(f[0], 6'h03, 32'hFF000000, 32'h0);
      rdc(f[0], 6'h04, 32'hFFFFFFFF, 32'h0);
      rdc(f[0], 6'h05, 32'hFFFF00FF, 32'h020000A0);
      rdc(f[0], 6'h28, 32'hFFFFFFFF, PM_WORD);
      rdc(f[0], 6'h29, 32'h3, 32'h0);
      wr(f[0], 6'h29, 4'h1, 32'h00000003);
      rdc(f[0], 6'h29, 32'h3, 32'h3);
    end
    $display("reset values done");
    wr(1'b0, 6'h04, 4'hF, 32'hFFFFFFFF);
    rdc(1'b0, 6'h04, 32'hFFFFFFFF, 32'hFFFFF000);
    rdc(1'b1, 6'h04, 32'hFFFFFFFF, 32'h0);
    wr(1'b1, 6'h04, 4'hF, 32'h12345678);
    rdc(1'b1, 6'h04, 32'hFFFFFFFF, 32'h12345000);
    rdc(1'b0, 6'h04, 32'hFFFFFFFF, 32'hFFFFF000);
    mem(32'h12345004, 2'h2, 2'h0);
    mem(32'h12345800, 2'h0, 2'h2);
    mem(32'hFFFFF9AB, 2'h0, 2'h1);
    mem(32'h00000010, 2'h0, 2'h0);
    $display("window done");
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 5; k++) begin
        card.strobe(k, f);
        repeat (3) @(negedge core_clk_in);
        rdc(f[0], 6'h05, 32'hFFFF0000, {16'h0200 | (16'h1 << pos[k]), 16'h0});
        rdc(~f[0], 6'h05, 32'hFFFF0000, 32'h02000000);
        wr(f[0], 6'h05, 4'h8, 32'h0);
        rdc(f[0], 6'h05, 32'hFFFF0000, {16'h0200 | (16'h1 << pos[k]), 16'h0});
        wr(f[0], 6'h05, 4'h8, 32'hFF000000);
        rdc(f[0], 6'h05, 32'hFFFF0000, 32'h02000000);
      end
    end
    $display("status flags done");
    // bit 8 needs all three conditions at once
    for (int c = 0; c < 3; c++) begin
      card_master_data_phase_in = {2{c != 1}};
      parity_response_enable_in = {2{c != 0}};
      card.strobe(5, 0);
      repeat (3) @(negedge core_clk_in);
      rdc(1'b0, 6'h05, 32'h01000000, {7'h0, c == 2, 24'h0});
      wr(1'b0, 6'h05, 4'h8, 32'h01000000);
    end
    $display("data parity done");
    card.strobe(0, 1);
    do_reset();
    rdc(1'b1, 6'h05, 32'hFFFF0000, 32'h02000000);
    rdc(1'b1, 6'h04, 32'hFFFFFFFF, 32'h0);
    $display("second reset done");
    results();
  end
endmodule : tb_top
